// ===== logic/slt_pkg.sv
package slt_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] SLT_ADDR_ERR_TALLY = 8'h57;
    localparam logic [7:0] SLT_ADDR_CONTROL = 8'hB3;
    localparam logic [7:0] SLT_ADDR_FAR_STATUS = 8'hD0;
    localparam logic [7:0] SLT_ADDR_PIN_FUNC = 8'h10;
    localparam logic [7:0] SLT_CTRL_RESET = 8'h00;
    localparam logic [7:0] SLT_CTRL_START = 8'h01;
    localparam logic [7:0] SLT_CTRL_STOP = 8'h00;
    localparam int SLT_CTRL_ENABLE_BIT = 0;
    localparam int SLT_CLK_SEL_LO = 1;
    localparam int SLT_OUT_GATE_LO = 6;
    localparam int SLT_FAR_ACTIVE_BIT = 5;
    localparam logic [1:0] SLT_GATE_OFF = 2'h0;
    localparam logic [1:0] SLT_GATE_ON = 2'h2;
    localparam logic [7:0] SLT_TALLY_LOST = 8'hFF;
    localparam logic [7:0] SLT_TALLY_MAX = 8'hFE;
    localparam logic [7:0] SLT_TALLY_RESET = 8'h00;
    localparam int SLT_PORTS = 4;

    // far-end serializer register and field
    localparam logic [7:0] SLT_FAR_CLK_REG = 8'h14;
    localparam int SLT_FAR_CLK_LO = 1;
    localparam logic [7:0] SLT_FAR_MODE_REG = 8'h15;
    localparam logic [7:0] SLT_FAR_MODE_ON = 8'h01;
    localparam logic [7:0] SLT_FAR_MODE_OFF = 8'h00;

    // pin function codes
    localparam logic [2:0] SLT_PIN_FN_PASS = 3'h1;
    localparam logic [2:0] SLT_PIN_FN_LOCK = 3'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       req;
        logic       write;
        logic [1:0] port;
        logic [7:0] addr;
        logic [7:0] wdata;
    } slt_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } slt_far_wr_t;

endpackage : slt_pkg

// ===== logic/slt_link_self_test.sv
`timescale 1ns/1ps
module slt_link_self_test (
    input wire logic ref_clk_i,                          // 20 MHz clock
    input wire logic rst_i,                              // sync reset, high
    input wire slt_pkg::slt_reg_req_t i2c_req_i,         // local I2C register access
    input wire slt_pkg::slt_reg_req_t bc_req_i,          // back-channel register access
    input wire logic [3:0] rx_lock_i,                    // receiver lock per port
    input wire logic [3:0] rx_bit_err_i,                 // pattern checker error pulse per port
    input wire logic far_test_active_i,                  // far end reports test mode
    input wire logic far_wr_ready_i,                     // back-channel write slot free
    input wire logic pgen_csi_active_i,                  // pattern generator drives CSI-2
    input wire logic monitor_i,                          // monitor source
    output logic [7:0] rdata_o,                          // read data
    output logic rvalid_o,                               // read data valid
    output slt_pkg::slt_far_wr_t far_wr_o,               // back-channel write to serializer
    output logic test_running_o,                         // test in progress
    output logic check_enable_o,                         // pattern checkers armed
    output logic outputs_enable_o,                       // device outputs allowed
    output logic csi_lp11_o,                             // CSI-2 held in LP11
    output logic [3:0] gpio_o,                           // pin levels
    output logic monitor_o                               // monitor output
);
    import slt_pkg::*;

    // ==========================================================
    // access arbitration
    slt_reg_req_t acc;
    always_comb begin
        acc = i2c_req_i.req ? i2c_req_i : bc_req_i;
    end

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v >= SLT_TALLY_MAX) ? v : v + 8'h01;
    endfunction : sat_inc

    // ==========================================================
    // control register
    logic [7:0] ctrl_q;
    logic [7:0] pin_func_q [SLT_PORTS];
    wire logic wr_ctrl = acc.req && acc.write && acc.addr == SLT_ADDR_CONTROL;
    wire logic start = wr_ctrl && acc.wdata[SLT_CTRL_ENABLE_BIT] && !ctrl_q[SLT_CTRL_ENABLE_BIT];
    wire logic stop = wr_ctrl && !acc.wdata[SLT_CTRL_ENABLE_BIT] && ctrl_q[SLT_CTRL_ENABLE_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q <= SLT_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= acc.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < SLT_PORTS; p++) begin
                pin_func_q[p] <= 8'h00;
            end
        end else if (acc.req && acc.write && acc.addr == SLT_ADDR_PIN_FUNC) begin
            pin_func_q[acc.port] <= acc.wdata;
        end
    end

    // ==========================================================
    // clock select sampled at start
    logic [1:0] clk_sel_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_sel_q <= 2'h0;
        end else if (start) begin
            clk_sel_q <= acc.wdata[SLT_CLK_SEL_LO +: 2];
        end
    end

    // ==========================================================
    // far-end configuration sequence
    typedef enum logic [2:0] {SLT_IDLE, SLT_CFG_CLK, SLT_CFG_MODE, SLT_RUN, SLT_STOP} slt_state_t;
    slt_state_t state_q;
    slt_far_wr_t far_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= SLT_IDLE;
            far_q <= '0;
        end else begin
            far_q.valid <= 1'b0;
            unique case (state_q)
                SLT_IDLE: begin
                    if (start) begin
                        state_q <= SLT_CFG_CLK;
                    end
                end
                SLT_CFG_CLK: begin
                    // stop during setup still turns the far end off
                    if (stop) begin
                        state_q <= SLT_STOP;
                    end else if (far_wr_ready_i) begin
                        far_q.valid <= 1'b1;
                        far_q.addr <= SLT_FAR_CLK_REG;
                        far_q.data <= {5'h00, clk_sel_q, 1'b0};
                        state_q <= SLT_CFG_MODE;
                    end
                end
                SLT_CFG_MODE: begin
                    if (stop) begin
                        state_q <= SLT_STOP;
                    end else if (far_wr_ready_i) begin
                        far_q.valid <= 1'b1;
                        far_q.addr <= SLT_FAR_MODE_REG;
                        far_q.data <= SLT_FAR_MODE_ON;
                        state_q <= SLT_RUN;
                    end
                end
                SLT_RUN: begin
                    if (stop) begin
                        state_q <= SLT_STOP;
                    end
                end
                SLT_STOP: begin
                    if (far_wr_ready_i) begin
                        far_q.valid <= 1'b1;
                        far_q.addr <= SLT_FAR_MODE_REG;
                        far_q.data <= SLT_FAR_MODE_OFF;
                        state_q <= SLT_IDLE;
                    end
                end
            endcase
        end
    end

    wire logic running = ctrl_q[SLT_CTRL_ENABLE_BIT];
    wire logic checking = state_q == SLT_RUN;

    // ==========================================================
    // per-port error tallies
    logic [7:0] tally_q [SLT_PORTS];
    logic [3:0] locked_once_q;
    logic [3:0] lock_lost_q;
    // pass level low in the same cycle as each error pulse seen while checking; gpio_o follows a cycle later
    wire logic [3:0] pass = ~({4{checking}} & rx_bit_err_i);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            locked_once_q <= 4'h0;
            lock_lost_q <= 4'h0;
            for (int p = 0; p < SLT_PORTS; p++) begin
                tally_q[p] <= SLT_TALLY_RESET;
            end
        end else if (start) begin
            locked_once_q <= 4'h0;
            lock_lost_q <= 4'h0;
            for (int p = 0; p < SLT_PORTS; p++) begin
                tally_q[p] <= SLT_TALLY_RESET;
            end
        end else if (checking) begin
            for (int p = 0; p < SLT_PORTS; p++) begin
                if (rx_lock_i[p]) begin
                    locked_once_q[p] <= 1'b1;
                end else if (locked_once_q[p]) begin
                    lock_lost_q[p] <= 1'b1;
                end
                if (rx_lock_i[p] && rx_bit_err_i[p]) begin
                    tally_q[p] <= sat_inc(tally_q[p]);
                end
            end
        end
    end

    // ==========================================================
    // register reads
    function automatic logic [7:0] tally_view(input logic [1:0] p);
        tally_view = (lock_lost_q[p] || !locked_once_q[p]) ? SLT_TALLY_LOST : tally_q[p];
    endfunction : tally_view

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= acc.req && !acc.write;
            if (acc.req && !acc.write) begin
                unique case (acc.addr)
                    SLT_ADDR_ERR_TALLY: rdata_o <= tally_view(acc.port);
                    SLT_ADDR_CONTROL: rdata_o <= ctrl_q;
                    SLT_ADDR_FAR_STATUS: rdata_o <= {2'h0, far_test_active_i, 5'h00};
                    SLT_ADDR_PIN_FUNC: rdata_o <= pin_func_q[acc.port];
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // output gating and pins
    wire logic gate_on = ctrl_q[SLT_OUT_GATE_LO +: 2] == SLT_GATE_ON;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            test_running_o <= 1'b0;
            check_enable_o <= 1'b0;
            outputs_enable_o <= 1'b1;
            csi_lp11_o <= 1'b1;
            monitor_o <= 1'b0;
            gpio_o <= 4'h0;
        end else begin
            // follow the control write in the same cycle it lands
            test_running_o <= wr_ctrl ? acc.wdata[SLT_CTRL_ENABLE_BIT] : running;
            check_enable_o <= checking;
            outputs_enable_o <= !running || gate_on;
            csi_lp11_o <= !pgen_csi_active_i;
            monitor_o <= monitor_i;
            for (int p = 0; p < SLT_PORTS; p++) begin
                if (pin_func_q[p][2:0] == SLT_PIN_FN_PASS) begin
                    gpio_o[p] <= pass[p];
                end else if (pin_func_q[p][2:0] == SLT_PIN_FN_LOCK) begin
                    gpio_o[p] <= rx_lock_i[p];
                end else begin
                    gpio_o[p] <= 1'b0;
                end
            end
        end
    end

    assign far_wr_o = far_q;

endmodule : slt_link_self_test

// ===== testbench/slt_far_model.sv
`timescale 1ns/1ps
module slt_far_model
    import slt_pkg::*;
(
    input wire logic ref_clk_i,              // clock
    input wire logic rst_i,                  // sync reset
    input wire slt_pkg::slt_far_wr_t wr_i,   // back-channel writes
    input wire logic slow_i,                 // stall most cycles
    output logic ready_o,                    // write slot free
    output logic active_o,                   // test mode on
    output logic [7:0] clk_reg_q,            // clock select register
    output int n_wr                          // writes seen
);
    logic [1:0] cnt_q;
    always_ff @(posedge ref_clk_i) cnt_q <= rst_i ? 2'h0 : cnt_q + 2'h1;
    assign ready_o = !slow_i || cnt_q == 2'h0;
    // frames arrive with a clean crc, so no back-channel errors are tracked
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
            clk_reg_q <= 8'h00;
            n_wr <= 0;
        end else if (wr_i.valid) begin
            n_wr <= n_wr + 1;
            if (wr_i.addr == SLT_FAR_CLK_REG) clk_reg_q <= wr_i.data; // 00 external, else internal
            if (wr_i.addr == SLT_FAR_MODE_REG) active_o <= wr_i.data == SLT_FAR_MODE_ON; // sends pattern
        end
    end
endmodule : slt_far_model

// ===== testbench/slt_link_self_test_asserts.sv
`timescale 1ns/1ps
module slt_link_self_test_asserts
    import slt_pkg::*;
(
    input wire logic ref_clk_i, rst_i, far_test_active_i, far_wr_ready_i, pgen_csi_active_i, monitor_i,
    input wire slt_pkg::slt_reg_req_t i2c_req_i, bc_req_i,
    input wire logic [3:0] rx_lock_i, rx_bit_err_i, gpio_o,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o, test_running_o, check_enable_o, outputs_enable_o, csi_lp11_o, monitor_o,
    input wire slt_pkg::slt_far_wr_t far_wr_o
);
    slt_reg_req_t eff;
    logic [7:0] ctrl_q;
    logic [1:0] sel_q;
    logic [2:0] pf0_q;
    logic wr_ctrl;
    assign eff = i2c_req_i.req ? i2c_req_i : bc_req_i;
    assign wr_ctrl = eff.req && eff.write && eff.addr == SLT_ADDR_CONTROL;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) ctrl_q <= SLT_CTRL_RESET;
        else if (wr_ctrl) ctrl_q <= eff.wdata;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) sel_q <= 2'h0;
        else if (wr_ctrl && eff.wdata[0] && !ctrl_q[0]) sel_q <= eff.wdata[2:1];
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) pf0_q <= 3'h0;
        else if (eff.req && eff.write && eff.addr == SLT_ADDR_PIN_FUNC && eff.port == 2'h0) pf0_q <= eff.wdata[2:0];
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_clk_wr; far_wr_o.valid && far_wr_o.addr == SLT_FAR_CLK_REG; endsequence
    sequence s_mode_on; far_wr_o.valid && far_wr_o.addr == SLT_FAR_MODE_REG && far_wr_o.data == SLT_FAR_MODE_ON; endsequence
    a_read_answer: assert property (eff.req && !eff.write |=> rvalid_o) else $error("read not answered");
    a_start_runs: assert property (wr_ctrl && eff.wdata[0] |=> test_running_o) else $error("no start");
    a_stop_halts: assert property (wr_ctrl && eff.wdata == SLT_CTRL_STOP |=> !test_running_o) else $error("no stop");
    a_clk_forward: assert property (s_clk_wr |-> far_wr_o.data[2:1] == sel_q && !far_wr_o.data[0])
        else $error("clock select wrong");
    a_mode_follows: assert property (s_clk_wr |-> ##[1:20] s_mode_on) else $error("no test mode write");
    a_pass_low: assert property (check_enable_o && pf0_q == SLT_PIN_FN_PASS && rx_bit_err_i[0] |=> !gpio_o[0])
        else $error("pass pin not low");
    a_out_gating: assert property ($stable(ctrl_q) |-> outputs_enable_o == (!ctrl_q[0] || ctrl_q[7:6] == SLT_GATE_ON))
        else $error("output gating wrong");
    a_lp11_idle: assert property (check_enable_o && !pgen_csi_active_i |=> csi_lp11_o) else $error("csi not idle");
    a_far_status: assert property (eff.req && !eff.write && eff.addr == SLT_ADDR_FAR_STATUS && $stable(far_test_active_i)
        |=> rdata_o[SLT_FAR_ACTIVE_BIT] == $past(far_test_active_i)) else $error("status bit wrong");
endmodule : slt_link_self_test_asserts
bind slt_link_self_test slt_link_self_test_asserts u_chk (.ref_clk_i, .rst_i, .far_test_active_i, .far_wr_ready_i,
    .pgen_csi_active_i, .monitor_i, .i2c_req_i, .bc_req_i, .rx_lock_i, .rx_bit_err_i, .gpio_o, .rdata_o, .rvalid_o,
    .test_running_o, .check_enable_o, .outputs_enable_o, .csi_lp11_o, .monitor_o, .far_wr_o);

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import slt_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, slow = 1'b1, pgen = 1'b0, mon = 1'b0;
    slt_reg_req_t i2c_req = '0, bc_req = '0;
    logic [3:0] lock = 4'h0, err = 4'h0, gpio;
    logic far_act, far_rdy, rvalid, running, check_en, out_en, lp11, mon_o;
    logic [7:0] rdata, far_clk, v;
    slt_far_wr_t far_wr;
    int mismatches = 0, n_compared = 0, far_n, snap;
    slt_link_self_test dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .i2c_req_i(i2c_req), .bc_req_i(bc_req),
        .rx_lock_i(lock), .rx_bit_err_i(err), .far_test_active_i(far_act), .far_wr_ready_i(far_rdy),
        .pgen_csi_active_i(pgen), .monitor_i(mon), .rdata_o(rdata), .rvalid_o(rvalid), .far_wr_o(far_wr),
        .test_running_o(running), .check_enable_o(check_en), .outputs_enable_o(out_en), .csi_lp11_o(lp11),
        .gpio_o(gpio), .monitor_o(mon_o));
    slt_far_model u_far (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(far_wr), .slow_i(slow), .ready_o(far_rdy),
        .active_o(far_act), .clk_reg_q(far_clk), .n_wr(far_n));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input bit bc, input logic wr, input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        if (bc) bc_req = '{1'b1, wr, p, a, d};
        else i2c_req = '{1'b1, wr, p, a, d};
        @(negedge ref_clk_i);
        i2c_req = '0;
        bc_req = '0;
        v = rdata;
        if (!wr) chk({7'h0, rvalid}, 8'h01);
    endtask : acc
    task automatic wait_run;
        repeat (40) if (!check_en) @(negedge ref_clk_i);
    endtask : wait_run
    task automatic t_start;
        chk({7'h0, out_en}, 8'h01);
        acc(0, 0, 2'h0, SLT_ADDR_CONTROL, 8'h00); chk(v, SLT_CTRL_RESET);
        acc(0, 0, 2'h0, SLT_ADDR_ERR_TALLY, 8'h00); chk(v, SLT_TALLY_LOST);
        lock = 4'hF;
        acc(0, 1, 2'h0, SLT_ADDR_PIN_FUNC, {5'h0, SLT_PIN_FN_PASS});
        acc(0, 1, 2'h1, SLT_ADDR_PIN_FUNC, {5'h0, SLT_PIN_FN_LOCK});
        acc(0, 1, 2'h0, SLT_ADDR_CONTROL, 8'h85);
        wait_run();
        chk({7'h0, check_en}, 8'h01);
        chk(far_clk, 8'h04);
        acc(0, 0, 2'h0, SLT_ADDR_FAR_STATUS, 8'h00); chk(v & 8'h20, 8'h20);
        chk({7'h0, out_en}, 8'h01);
        snap = far_n;
        acc(0, 1, 2'h0, SLT_ADDR_CONTROL, 8'h83);
        repeat (8) @(negedge ref_clk_i);
        chk(8'(far_n - snap), 8'h00);
        $display("t_start done");
    endtask : t_start
    task automatic t_errors;
        pgen = 1'b1;
        mon = 1'b1;
        repeat (3) begin
            @(negedge ref_clk_i); err[0] = 1'b1;
            @(negedge ref_clk_i); err[0] = 1'b0;
            chk({7'h0, gpio[0]}, 8'h00);
        end
        chk({7'h0, gpio[1]}, 8'h01);
        chk({7'h0, lp11}, 8'h00);
        chk({7'h0, mon_o}, 8'h01);
        err[2] = 1'b1;
        repeat (300) @(negedge ref_clk_i);
        err[2] = 1'b0;
        lock[3] = 1'b0;
        acc(0, 0, 2'h0, SLT_ADDR_ERR_TALLY, 8'h00); chk(v, 8'h03);
        acc(0, 0, 2'h2, SLT_ADDR_ERR_TALLY, 8'h00); chk(v, SLT_TALLY_MAX);
        acc(1, 0, 2'h3, SLT_ADDR_ERR_TALLY, 8'h00); chk(v, SLT_TALLY_LOST);
        $display("t_errors done");
    endtask : t_errors
    task automatic t_restart;
        acc(1, 1, 2'h0, SLT_ADDR_CONTROL, SLT_CTRL_STOP);
        repeat (40) if (far_act) @(negedge ref_clk_i);
        chk({7'h0, far_act}, 8'h00);
        chk({7'h0, running}, 8'h00);
        lock[3] = 1'b1;
        slow = 1'b0;
        acc(0, 1, 2'h0, SLT_ADDR_CONTROL, SLT_CTRL_START);
        wait_run();
        chk({7'h0, out_en}, 8'h00);
        chk(far_clk, 8'h00);
        acc(0, 0, 2'h0, SLT_ADDR_ERR_TALLY, 8'h00); chk(v, SLT_TALLY_RESET);
        acc(0, 1, 2'h0, SLT_ADDR_CONTROL, SLT_CTRL_STOP);
        $display("t_restart done");
    endtask : t_restart
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #1000000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_start();
        t_errors();
        t_restart();
        wrap_up();
    end
endmodule : tb_top
